/* File: src/cwd_pkg.sv */
// shared constants and types for the core watchdog and reset-cause block
package cwd_pkg;

    // register byte offsets on the apb bus
    localparam logic [11:0] CWD_OFS_CAUSE = 12'h000;
    localparam logic [11:0] CWD_OFS_CTRL = 12'h004;
    localparam logic [11:0] CWD_OFS_SVC = 12'h008;
    localparam logic [11:0] CWD_OFS_ISTAT = 12'h00c;
    localparam logic [11:0] CWD_OFS_IMASK = 12'h010;

    // watchdog_control field positions
    localparam int CWD_CTRL_EN_BIT = 7;
    localparam int CWD_CTRL_RI_BIT = 6;
    localparam int CWD_CTRL_TSEL_MSB = 5;
    localparam int CWD_CTRL_TSEL_LSB = 3;
    localparam int CWD_CTRL_BACK_EN_BIT = 2;
    localparam int CWD_CTRL_BACK_OCC_BIT = 1;
    localparam int CWD_CTRL_TIF_BIT = 0;

    // core_reset_cause field position
    localparam int CWD_CAUSE_EXT_BIT = 7;

    // irq_status / irq_mask field positions
    localparam int CWD_IRQ_TMO_BIT = 0;
    localparam int CWD_IRQ_BACK_BIT = 1;

    // reset values
    localparam logic [7:0] CWD_CAUSE_RST = 8'h00;
    localparam logic [1:0] CWD_ISTAT_RST = 2'h0;
    localparam logic [1:0] CWD_IMASK_RST = 2'h0;
    localparam logic [31:0] CWD_CNT_RST = 32'h0000_0000;

    // service sequence keys
    localparam logic [7:0] CWD_SVC_KEY1 = 8'h55;
    localparam logic [7:0] CWD_SVC_KEY2 = 8'haa;

    // timeout exponents, index = timeout_select code
    localparam logic [7:0][4:0] CWD_TMO_EXP = {
        5'h1f, 5'h1b, 5'h17, 5'h13, 5'h0f, 5'h0d, 5'h0b, 5'h09
    };

    // cycles after reset release before the cause is recorded; the
    // filtered pin settles on the fourth edge, so record on the fifth
    localparam logic [2:0] CWD_BOOT_CYC = 3'h5;

    typedef struct packed {
        logic en;
        logic [2:0] tsel;
        logic back_en;
        logic back_occ;
        logic tif;
    } cwd_ctrl_t;

    localparam cwd_ctrl_t CWD_CTRL_RST = '{
        en: 1'b0, tsel: 3'h0, back_en: 1'b0, back_occ: 1'b0, tif: 1'b0
    };

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cwd_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cwd_apb_rsp_t;

    typedef enum logic {
        CWD_SVC_IDLE,
        CWD_SVC_ARMED
    } cwd_svc_st_t;

endpackage

/* File: src/cwd_sync3.sv */
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ns
module cwd_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } cwd_sync_st_t;

    cwd_sync_st_t s_r;
    cwd_sync_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = din;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        // only stages two and three are compared, never the first
        if (s_r.s2 == s_r.s3) begin
            s_nxt.q = s_r.s3;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.q;

endmodule // cwd_sync3

/* File: src/cwd_service.sv */
// two-key service sequence detector for the watchdog
`timescale 1ns/1ns
module cwd_service (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic done
);

    typedef struct packed {
        cwd_pkg::cwd_svc_st_t st;
    } cwd_svc_state_t;

    cwd_svc_state_t s_r;
    cwd_svc_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        done = 1'b0;
        if (wr) begin
            unique case (s_r.st)
                cwd_pkg::CWD_SVC_IDLE: begin
                    if (wdata == cwd_pkg::CWD_SVC_KEY1) begin
                        s_nxt.st = cwd_pkg::CWD_SVC_ARMED;
                    end
                end
                cwd_pkg::CWD_SVC_ARMED: begin
                    // other writes between the keys keep the sequence armed
                    if (wdata == cwd_pkg::CWD_SVC_KEY2) begin
                        done = 1'b1;
                        s_nxt.st = cwd_pkg::CWD_SVC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{st: cwd_pkg::CWD_SVC_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // cwd_service

/* File: src/cwd_core.sv */
// core watchdog timer with reset-cause register behind an apb slave
`timescale 1ns/1ns

// Notes on behaviour
// - reset cause records the latest reset kind once reset has completed
// - at most one reset-cause bit is ever set
// - writing one clears a reset-cause bit, writing zero leaves it
// - bit 7 marks an external reset, other cause bits reset to zero
// - watchdog counts only while enable bit 7 is set, cleared by reset
// - missing service within the period sets the timeout flag and irq
// - writing 0x55 then 0xaa to the service register restarts the count unless a timeout is pending
// - unacknowledged irq after another period pulses bus acknowledge
// - bus acknowledge sets the bus-ack-occurred flag
// - count compared continuously with the selected period
// - enable, select and bus-ack-enable writes are ignored while a timeout is pending
// - reset-or-irq select bit 6 is fixed at zero
// - select codes 0 to 3 give 2^9, 2^11, 2^13, 2^15 clocks
// - select codes 4 to 7 give 2^19, 2^23, 2^27, 2^31 clocks
// - timeout flag bit 0 is write-one-to-clear
// - bus-ack-occurred flag bit 1 is write-one-to-clear
// - service writes after a timeout do not clear the pending flag
module cwd_core #(
    parameter logic [7:0][4:0] TMO_EXP = cwd_pkg::CWD_TMO_EXP
) (
    input wire logic clk,
    input wire logic rst,
    input cwd_pkg::cwd_apb_req_t apb_req,
    output cwd_pkg::cwd_apb_rsp_t apb_rsp,
    input wire logic ext_reset_src,
    input wire logic irq_ack,
    output logic wdog_irq_req,
    output logic bus_cycle_acknowledge,
    output logic irq
);

    typedef struct packed {
        logic [31:0] cnt;
        cwd_pkg::cwd_ctrl_t ctrl;
        logic [7:0] cause;
        logic [2:0] boot;
        logic [1:0] istat;
        logic [1:0] imask;
        logic [31:0] rdata;
        logic slverr;
        logic back;
    } cwd_state_t;

    cwd_state_t s_r;
    cwd_state_t s_nxt;

    logic ext_q;
    logic setup;
    logic wr;
    logic svc_wr;
    logic svc_done;
    logic pending;
    logic hit;
    logic tif_set;
    logic tif_clr;
    logic [31:0] period;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [31:0] tmo_period(input logic [2:0] sel);
        tmo_period = 32'h1 << TMO_EXP[sel];
    endfunction

    function automatic logic ofs_is(input logic [11:0] addr,
                                    input logic [11:0] ofs);
        ofs_is = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // submodules

    cwd_sync3 u_ext_sync (
        .clk(clk),
        .rst(rst),
        .din(ext_reset_src),
        .dout(ext_q)
    );

    assign setup = apb_req.psel & ~apb_req.penable;
    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign svc_wr = wr & ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_SVC);

    cwd_service u_service (
        .clk(clk),
        .rst(rst),
        .wr(svc_wr),
        .wdata(apb_req.pwdata[7:0]),
        .done(svc_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    assign pending = s_r.ctrl.tif;
    assign period = tmo_period(s_r.ctrl.tsel);
    // >= so a shorter select takes hold at once, even past the new end
    assign hit = s_r.ctrl.en & (s_r.cnt >= period - 32'h1);
    assign tif_set = hit & ~pending & ~svc_done;
    assign tif_clr = irq_ack | (wr & apb_req.pwdata[cwd_pkg::CWD_CTRL_TIF_BIT]
        & ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL));

    always_comb begin
        s_nxt = s_r;
        s_nxt.back = 1'b0;

        // boot counter waits for the filtered pin to settle after release
        if (s_r.boot != cwd_pkg::CWD_BOOT_CYC) begin
            s_nxt.boot = s_r.boot + 3'h1;
        end

        // register writes take effect in the access cycle
        if (wr) begin
            if (ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CAUSE)) begin
                s_nxt.cause = s_nxt.cause & ~apb_req.pwdata[7:0];
            end
            if (ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL)) begin
                if (!pending) begin
                    s_nxt.ctrl.en = apb_req.pwdata[cwd_pkg::CWD_CTRL_EN_BIT];
                    s_nxt.ctrl.tsel = apb_req.pwdata[
                        cwd_pkg::CWD_CTRL_TSEL_MSB:cwd_pkg::CWD_CTRL_TSEL_LSB];
                    s_nxt.ctrl.back_en =
                        apb_req.pwdata[cwd_pkg::CWD_CTRL_BACK_EN_BIT];
                end
                if (apb_req.pwdata[cwd_pkg::CWD_CTRL_BACK_OCC_BIT]) begin
                    s_nxt.ctrl.back_occ = 1'b0;
                end
            end
            if (ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_ISTAT)) begin
                s_nxt.istat = s_r.istat & ~apb_req.pwdata[1:0];
            end
            if (ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_IMASK)) begin
                s_nxt.imask = apb_req.pwdata[1:0];
            end
        end
        // recorded after the write clears, so a new cause always lands
        if (s_r.boot == cwd_pkg::CWD_BOOT_CYC - 3'h1) begin
            // a new cause replaces the whole register
            s_nxt.cause = cwd_pkg::CWD_CAUSE_RST;
            s_nxt.cause[cwd_pkg::CWD_CAUSE_EXT_BIT] = ext_q;
        end
        if (tif_clr) begin
            s_nxt.ctrl.tif = 1'b0;
        end

        // counter and timeout events; events are applied after the clears
        if (svc_done && !pending) begin
            s_nxt.cnt = cwd_pkg::CWD_CNT_RST;
        end else if (s_r.ctrl.en) begin
            if (hit) begin
                // each period end starts the next one from zero
                s_nxt.cnt = cwd_pkg::CWD_CNT_RST;
                if (!pending) begin
                    // never a device reset, always an interrupt
                    s_nxt.ctrl.tif = 1'b1;
                    s_nxt.istat[cwd_pkg::CWD_IRQ_TMO_BIT] = 1'b1;
                end else if (s_r.ctrl.back_en) begin
                    s_nxt.back = 1'b1;
                    s_nxt.ctrl.back_occ = 1'b1;
                    s_nxt.istat[cwd_pkg::CWD_IRQ_BACK_BIT] = 1'b1;
                end
            end else begin
                s_nxt.cnt = s_r.cnt + 32'h1;
            end
        end
        // a service write while pending leaves the flag alone

        // read data and error are prepared in the setup cycle
        if (setup) begin
            s_nxt.slverr = 1'b0;
            s_nxt.rdata = 32'h0000_0000;
            unique case (apb_req.paddr)
                cwd_pkg::CWD_OFS_CAUSE: s_nxt.rdata[7:0] = s_r.cause;
                cwd_pkg::CWD_OFS_CTRL: begin
                    s_nxt.rdata[cwd_pkg::CWD_CTRL_EN_BIT] = s_r.ctrl.en;
                    s_nxt.rdata[cwd_pkg::CWD_CTRL_RI_BIT] = 1'b0;
                    s_nxt.rdata[cwd_pkg::CWD_CTRL_TSEL_MSB:
                        cwd_pkg::CWD_CTRL_TSEL_LSB] = s_r.ctrl.tsel;
                    s_nxt.rdata[cwd_pkg::CWD_CTRL_BACK_EN_BIT] =
                        s_r.ctrl.back_en;
                    s_nxt.rdata[cwd_pkg::CWD_CTRL_BACK_OCC_BIT] =
                        s_r.ctrl.back_occ;
                    s_nxt.rdata[cwd_pkg::CWD_CTRL_TIF_BIT] = s_r.ctrl.tif;
                end
                cwd_pkg::CWD_OFS_SVC: s_nxt.rdata = 32'h0000_0000;
                cwd_pkg::CWD_OFS_ISTAT: s_nxt.rdata[1:0] = s_r.istat;
                cwd_pkg::CWD_OFS_IMASK: s_nxt.rdata[1:0] = s_r.imask;
                default: s_nxt.slverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r.cnt <= cwd_pkg::CWD_CNT_RST;
            s_r.ctrl <= cwd_pkg::CWD_CTRL_RST;
            s_r.cause <= cwd_pkg::CWD_CAUSE_RST;
            s_r.boot <= 3'h0;
            s_r.istat <= cwd_pkg::CWD_ISTAT_RST;
            s_r.imask <= cwd_pkg::CWD_IMASK_RST;
            s_r.rdata <= 32'h0000_0000;
            s_r.slverr <= 1'b0;
            s_r.back <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // zero wait states keep the slave simple; reads see setup-time state
    assign apb_rsp.prdata = s_r.rdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = s_r.slverr & apb_req.psel & apb_req.penable;
    assign wdog_irq_req = s_r.ctrl.tif;
    assign bus_cycle_acknowledge = s_r.back;
    assign irq = |(s_r.istat & s_r.imask);

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_CAUSE_ONEHOT: assert property (
        $onehot0(s_r.cause))
        else $error("more than one reset cause bit set");

    AST_CAUSE_CAPTURE: assert property (
        s_r.boot == cwd_pkg::CWD_BOOT_CYC - 3'h1
        |=> s_r.cause[cwd_pkg::CWD_CAUSE_EXT_BIT] == $past(ext_q))
        else $error("reset cause not recorded after reset");

    AST_CAUSE_W1C: assert property (
        wr && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CAUSE)
        && apb_req.pwdata[7] && s_r.boot == cwd_pkg::CWD_BOOT_CYC
        |=> !s_r.cause[cwd_pkg::CWD_CAUSE_EXT_BIT])
        else $error("reset cause bit not cleared by one");

    AST_HOLD_DISABLED: assert property (
        !s_r.ctrl.en && !svc_done |=> $stable(s_r.cnt) && !s_r.back)
        else $error("counter moved while disabled");

    AST_TIMEOUT: assert property (
        s_r.ctrl.en && !pending && !svc_done
        && s_r.cnt >= tmo_period(s_r.ctrl.tsel) - 32'h1
        |=> s_r.ctrl.tif && s_r.cnt == 32'h0 && wdog_irq_req)
        else $error("timeout not flagged at period end");

    AST_COUNT_STEP: assert property (
        s_r.ctrl.en && !hit && !(svc_done && !pending)
        |=> s_r.cnt == $past(s_r.cnt) + 32'h1)
        else $error("counter did not advance by one");

    AST_SVC_RESTART: assert property (
        svc_done && !pending |=> s_r.cnt == 32'h0 ##1 !s_r.ctrl.tif)
        else $error("service did not restart the count");

    AST_BACK_PULSE: assert property (
        s_r.ctrl.en && pending && hit && s_r.ctrl.back_en
        |=> bus_cycle_acknowledge ##1 !bus_cycle_acknowledge)
        else $error("bus acknowledge not pulsed for one cycle");

    AST_BACK_FLAG: assert property (
        bus_cycle_acknowledge |-> s_r.ctrl.back_occ && $past(pending))
        else $error("bus acknowledge without its flag");

    AST_CTRL_LOCK: assert property (
        wr && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL) && pending
        |=> $stable(s_r.ctrl.en) && $stable(s_r.ctrl.tsel)
        && $stable(s_r.ctrl.back_en))
        else $error("control written while timeout pending");

    AST_RI_ZERO: assert property (
        setup && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL)
        |=> !apb_rsp.prdata[cwd_pkg::CWD_CTRL_RI_BIT])
        else $error("reset-or-irq select read as one");

    AST_TIF_W1C: assert property (
        tif_clr && !tif_set |=> !s_r.ctrl.tif)
        else $error("timeout flag not cleared");

    AST_SVC_NO_NEGATE: assert property (
        pending && svc_done && !tif_clr |=> s_r.ctrl.tif)
        else $error("service negated a pending timeout");

    AST_CAUSE_KEEP: assert property (
        s_r.boot == cwd_pkg::CWD_BOOT_CYC
        && !(wr && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CAUSE))
        |=> $stable(s_r.cause))
        else $error("reset cause changed without a write");

    AST_CAUSE_BOOT_ZERO: assert property (
        s_r.boot != cwd_pkg::CWD_BOOT_CYC
        |-> s_r.cause == cwd_pkg::CWD_CAUSE_RST)
        else $error("reset cause set before reset completed");

    AST_CTRL_WRITE: assert property (
        wr && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL) && !pending
        |=> s_r.ctrl.en == $past(apb_req.pwdata[cwd_pkg::CWD_CTRL_EN_BIT])
        && s_r.ctrl.tsel == $past(apb_req.pwdata[
            cwd_pkg::CWD_CTRL_TSEL_MSB:cwd_pkg::CWD_CTRL_TSEL_LSB]))
        else $error("control write not applied");

    AST_NO_TIF_DISABLED: assert property (
        !s_r.ctrl.en && !s_r.ctrl.tif |=> !s_r.ctrl.tif)
        else $error("timeout flagged while disabled");

    AST_TIF_STICKY: assert property (
        pending && !tif_clr |=> s_r.ctrl.tif)
        else $error("timeout flag dropped without a clear");

    AST_ISTAT_TMO: assert property (
        $rose(s_r.ctrl.tif) |-> s_r.istat[cwd_pkg::CWD_IRQ_TMO_BIT])
        else $error("timeout event not recorded in status");

    AST_BACK_ENABLED: assert property (
        bus_cycle_acknowledge
        |-> $past(s_r.ctrl.back_en) && $past(s_r.ctrl.en))
        else $error("bus acknowledge while not enabled");

    AST_BACK_OCC_W1C: assert property (
        wr && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL)
        && apb_req.pwdata[cwd_pkg::CWD_CTRL_BACK_OCC_BIT]
        && !(hit && pending && s_r.ctrl.back_en)
        |=> !s_r.ctrl.back_occ)
        else $error("bus-ack flag not cleared by one");

    AST_BACK_OCC_HOLD: assert property (
        s_r.ctrl.back_occ && !(wr
        && ofs_is(apb_req.paddr, cwd_pkg::CWD_OFS_CTRL)
        && apb_req.pwdata[cwd_pkg::CWD_CTRL_BACK_OCC_BIT])
        |=> s_r.ctrl.back_occ)
        else $error("bus-ack flag dropped without a clear");

    COV_TIMEOUT: cover property (!pending ##1 pending);
    COV_BACK: cover property (bus_cycle_acknowledge);
    COV_SVC: cover property (svc_done && !pending && s_r.ctrl.en);
    COV_EXT: cover property (s_r.cause[cwd_pkg::CWD_CAUSE_EXT_BIT]);

endmodule // cwd_core

/* File: sim/cwd_intc_model.sv */
// interrupt controller stand-in that acknowledges the watchdog request
`timescale 1ns/1ns
module cwd_intc_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_req,
    input wire logic ack_en,
    input wire logic [7:0] ack_delay,
    output logic irq_ack
);
    logic [7:0] wait_r;

    // with ack_en low it never answers, so the second period can elapse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_r <= 8'h00;
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= 1'b0;
            if (!(irq_req && ack_en) || irq_ack) begin
                wait_r <= 8'h00;
            end else if (wait_r == ack_delay) begin
                irq_ack <= 1'b1;
            end else begin
                wait_r <= wait_r + 8'h01;
            end
        end
    end
endmodule // cwd_intc_model

/* File: sim/tb_top.sv */
// self-checking bench for the core watchdog and reset-cause block
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    localparam logic [11:0] A_CAUSE = cwd_pkg::CWD_OFS_CAUSE;
    localparam logic [11:0] A_CTRL = cwd_pkg::CWD_OFS_CTRL;
    localparam logic [11:0] A_SVC = cwd_pkg::CWD_OFS_SVC;
    localparam logic [11:0] A_ISTAT = cwd_pkg::CWD_OFS_ISTAT;
    localparam logic [11:0] A_IMASK = cwd_pkg::CWD_OFS_IMASK;
    // short exponents keep every period within a few thousand clocks
    localparam logic [7:0][4:0] EXP = {5'h0a, 5'h09, 5'h08, 5'h07,
        5'h06, 5'h05, 5'h04, 5'h03};
    logic clk;
    logic rst;
    logic ext_reset_src;
    logic ack_en;
    logic [7:0] ack_delay;
    logic irq_ack;
    logic wdog_irq_req;
    logic bus_cycle_acknowledge;
    logic irq;
    cwd_pkg::cwd_apb_req_t req;
    cwd_pkg::cwd_apb_rsp_t rsp;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0;
    int t1;
    logic [31:0] rd;
    logic err;
    // select code is the row index, expected period beside it
    int per_tab[8] = '{8, 16, 32, 64, 128, 256, 512, 1024};
    logic [11:0] zero_addr[4] = '{A_CTRL, A_ISTAT, A_IMASK, A_SVC};

    cwd_core #(.TMO_EXP(EXP)) cwd_core_i (
        .clk(clk),
        .rst(rst),
        .apb_req(req),
        .apb_rsp(rsp),
        .ext_reset_src(ext_reset_src),
        .irq_ack(irq_ack),
        .wdog_irq_req(wdog_irq_req),
        .bus_cycle_acknowledge(bus_cycle_acknowledge),
        .irq(irq)
    );

    cwd_intc_model cwd_intc_model_i (
        .clk(clk),
        .rst(rst),
        .irq_req(wdog_irq_req),
        .ack_en(ack_en),
        .ack_delay(ack_delay),
        .irq_ack(irq_ack)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic note(input string name);
        $display("test %s finished", name);
    endtask

    // ends one idle cycle after the access edge, so no strobe is re-driven
    // in the time step that released it
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n == 20) begin
            `CHK(rsp.pready, 1'b1)
            tally_and_finish();
        end
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask

    // each edge shows the value launched by the edge before; returns the
    // cycle count of that launching edge
    task automatic wait_sig(input logic ack, output int at);
        int n;
        for (n = 0; n < 2100; n++) begin
            @(posedge clk);
            if ((ack ? bus_cycle_acknowledge : wdog_irq_req) === 1'b1) break;
        end
        at = cyc;
        if (n == 2100) begin
            `CHK(n, 0)
            tally_and_finish();
        end
    endtask

    task automatic stop();
        wr(A_CTRL, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_0000);
        wr(A_ISTAT, 32'h0000_0003);
        wr(A_SVC, 32'h0000_0055); // disable then restart
        wr(A_SVC, 32'h0000_00aa); // disable then restart
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        rst = 1'b1;
        ext_reset_src = 1'b1;
        ack_en = 1'b0;
        ack_delay = 8'h03;
        req = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(A_CAUSE, 32'h0000_0000); // not yet recorded
        for (i = 0; i < 4; i++) rdchk(zero_addr[i], 32'h0);
        apb(1'b0, 12'h014, 32'h0000_0000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        rdchk(A_CAUSE, 32'h0000_0080); // recorded cause
        wr(A_CAUSE, 32'h0000_007f);
        rdchk(A_CAUSE, 32'h0000_0080); // zeros leave it
        wr(A_CAUSE, 32'h0000_0080);
        rdchk(A_CAUSE, 32'h0000_0000);
        wr(A_IMASK, 32'h0000_0001);
        rdchk(A_IMASK, 32'h0000_0001);
        note("reset_and_cause");

        for (i = 0; i < 8; i++) begin
            wr(A_CTRL, 32'h0000_0080 | (32'(i) << 3));
            t0 = cyc;
            wait_sig(1'b0, t1);
            `CHK(t1 - t0, per_tab[i])
            `CHK(irq, 1'b1)
            stop();
            `CHK(wdog_irq_req, 1'b0)
            `CHK(irq, 1'b0)
        end
        note("timeout_rows");

        wr(A_CTRL, 32'h0000_0098);
        repeat (30) @(posedge clk);
        wr(A_SVC, 32'h0000_0055);
        apb(1'b0, A_CAUSE, 32'h0000_0000);
        wr(A_SVC, 32'h0000_0033);
        wr(A_SVC, 32'h0000_00aa);
        t0 = cyc;
        wait_sig(1'b0, t1);
        `CHK(t1 - t0, 64) // count restarted from zero
        stop();
        note("service");

        wr(A_CTRL, 32'h0000_00b8);
        repeat (100) @(posedge clk);
        wr(A_CTRL, 32'h0000_0080);
        @(posedge clk);
        `CHK(wdog_irq_req, 1'b1) // shorter period applies at once
        stop();
        note("select_change");

        wr(A_CTRL, 32'h0000_0094);
        wait_sig(1'b0, t0);
        wr(A_SVC, 32'h0000_0055);
        wr(A_SVC, 32'h0000_00aa);
        wr(A_CTRL, 32'h0000_0040);
        rdchk(A_CTRL, 32'h0000_0095); // write locked out
        `CHK(wdog_irq_req, 1'b1)
        wait_sig(1'b1, t1);
        `CHK(t1 - t0, 32)
        @(posedge clk);
        `CHK(bus_cycle_acknowledge, 1'b0)
        rdchk(A_CTRL, 32'h0000_0097);
        wr(A_CTRL, 32'h0000_0002);
        rdchk(A_CTRL, 32'h0000_0095);
        rdchk(A_ISTAT, 32'h0000_0003);
        stop();
        note("bus_ack");

        ack_en <= 1'b1;
        wr(A_CTRL, 32'h0000_0094);
        wait_sig(1'b0, t0);
        repeat (10) @(posedge clk);
        `CHK(wdog_irq_req, 1'b0) // acknowledged by the controller
        ack_en <= 1'b0;
        wr(A_CTRL, 32'h0000_0000);
        rdchk(A_CTRL, 32'h0000_0000); // no bus ack after an ack
        stop();
        note("irq_ack");

        wr(A_CTRL, 32'h0000_0080);
        wait_sig(1'b0, t0);
        rst <= 1'b1;
        ext_reset_src <= 1'b0;
        #1;
        `CHK(wdog_irq_req, 1'b0)
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk(A_CAUSE, 32'h0000_0000); // internal reset
        rdchk(A_CTRL, 32'h0000_0000);
        note("second_reset");
        tally_and_finish();
    end
endmodule // tb_top
